// [hdl/data_space_decoder.v]
// data-space decoder: register file, I/O, extended I/O, SRAM and EEPROM access
`timescale 1ns/1ps
`include "data_space_regs.vh"
// Functional notes
// - map registers, I/O, extended I/O, SRAM
// - data space size follows SRAM variant
// - I/O ops use 0x00-0x3F, data +0x20
// - extended I/O only via loads, stores
// - bit set, clear, skip on low I/O
// - bit op changes only addressed bit
// - status flags clear on writing one
// - SRAM access takes two cycles
// - direct address reaches whole space
// - displacement 0-63 added to Y or Z
// - X Y Z pointers, pre-dec, post-inc
// - all locations reachable in every mode
// - separate EEPROM space, registers in I/O
// - EEPROM read stalls four cycles
// - EEPROM write stalls two cycles
// - reset never aborts running EEPROM write
// - three plain general purpose I/O registers
// - master write enable self-clears after four
module data_space_decoder #(
  parameter SRAM_AW  = 10,
  parameter EE_AW    = 9,
  parameter EE_WRITE_CYCLES = 256
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // request from the load/store and I/O units
  input  wire        req,
  input  wire [2:0]  mode,
  input  wire [1:0]  ptr_sel,
  input  wire [11:0] direct_addr,
  input  wire [5:0]  disp,
  input  wire        is_store,
  input  wire        io_op,
  input  wire [1:0]  bit_op,
  input  wire [2:0]  bit_sel,
  input  wire [5:0]  io_addr,
  input  wire [7:0]  wdata,
  // hardware status flag events
  input  wire [7:0]  flag_set,
  // answer
  output reg  [7:0]  rdata_reg,
  output reg         done_reg,
  output reg         skip_reg,
  output reg         stall_reg,
  output reg         bad_op_reg,
  output reg         ee_busy_reg
);
  // -------------------------------------------------------------------
  // modes, bit ops and states
  // -------------------------------------------------------------------
  localparam M_DIRECT = 3'h0;
  localparam M_DISP   = 3'h1;
  localparam M_IND    = 3'h2;
  localparam M_PREDEC = 3'h3;
  localparam M_POSTIN = 3'h4;
  localparam B_NONE   = 2'h0;
  localparam B_SET    = 2'h1;
  localparam B_CLR    = 2'h2;
  localparam B_SKIP   = 2'h3;
  localparam S_IDLE   = 2'h0;
  localparam S_SRAM   = 2'h1;
  localparam S_STALL  = 2'h2;
  localparam [11:0] SPACE_TOP = `DS_SRAM_FIRST + (12'h001 << SRAM_AW) - 12'h001;

  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  reg [7:0] regfile [0:31];
  reg [7:0] sram [0:(1<<SRAM_AW)-1];
  reg [7:0] ext_io [0:159];
  reg [7:0] gpr_reg [0:2];
  reg [7:0] flags_reg;
  reg [7:0] ee_ctrl_reg;
  reg [7:0] ee_data_reg;
  reg [EE_AW-1:0] ee_addr_reg;
  reg [2:0] mwe_cnt_reg;
  reg [2:0] stall_cnt_reg;
  reg [1:0] state_reg;
  reg [11:0] sram_addr_reg;
  reg       sram_wr_reg;
  reg [7:0] sram_wd_reg;
  reg       ee_start_reg;
  wire [7:0] ee_rdata;
  wire       ee_busy;
  integer    i;

  ee_store #(.AW(EE_AW), .WRITE_CYCLES(EE_WRITE_CYCLES)) u_ee (
    .clk         (clk),
    .rst         (rst),
    .addr        (ee_addr_reg),
    .wdata       (ee_data_reg),
    .write_start (ee_start_reg),
    .rdata       (ee_rdata),
    .busy_reg    (ee_busy)
  );

  // -------------------------------------------------------------------
  // address generation
  // -------------------------------------------------------------------
  reg [4:0]  plo;
  reg [15:0] ptr;
  reg [15:0] eff16;
  reg [15:0] ptr_new;
  reg [11:0] addr;
  reg [5:0]  ioa;
  reg        in_reg, in_io, in_ext, in_sram, unmapped;
  always @* begin
    plo = (ptr_sel == 2'h0) ? `PTR_X_LO : (ptr_sel == 2'h1) ? `PTR_Y_LO : `PTR_Z_LO;
    ptr = {regfile[plo + 5'h01], regfile[plo]};
    ptr_new = ptr;
    eff16 = {4'h0, direct_addr};
    case (mode)
      M_DIRECT: eff16 = {4'h0, direct_addr};
      // displacement is only legal on Y and Z; X falls back to plain indirect
      M_DISP:   eff16 = (ptr_sel == 2'h0) ? ptr : ptr + {10'h000, disp};
      M_IND:    eff16 = ptr;
      M_PREDEC: begin
        eff16   = ptr - 16'h0001;
        ptr_new = eff16;
      end
      M_POSTIN: begin
        eff16   = ptr;
        ptr_new = ptr + 16'h0001;
      end
      default:  eff16 = ptr;
    endcase
    // I/O port ops see only 0x00-0x3F, placed at +0x20 in data space
    addr = io_op ? ({6'h00, io_addr} + `DS_IO_OFFSET) : eff16[11:0];
    ioa  = addr[5:0] - 6'h20;
    in_reg  = (addr <= `DS_REG_LAST) && (eff16[15:12] == 4'h0);
    in_io   = (addr >= `DS_IO_FIRST) && (addr <= `DS_IO_LAST) && (eff16[15:12] == 4'h0);
    in_ext  = (addr >= `DS_EXT_FIRST) && (addr <= `DS_EXT_LAST) && !io_op &&
              (eff16[15:12] == 4'h0);
    in_sram = (addr >= `DS_SRAM_FIRST) && (addr <= SPACE_TOP) && (eff16[15:12] == 4'h0);
    unmapped = !(in_reg || in_io || in_ext || in_sram) ||
               (bit_op != B_NONE && (!io_op || io_addr > `IO_BIT_LAST));
  end

  // -------------------------------------------------------------------
  // I/O read mux: unimplemented locations read zero
  // -------------------------------------------------------------------
  reg [7:0] io_rd;
  always @* begin
    case (ioa)
      `IO_GPR0:       io_rd = gpr_reg[0];
      `IO_GPR1:       io_rd = gpr_reg[1];
      `IO_GPR2:       io_rd = gpr_reg[2];
      `IO_FLAGS:      io_rd = flags_reg;
      `IO_EE_CTRL:    io_rd = {ee_ctrl_reg[7:2], ee_busy, ee_ctrl_reg[0]} & `EE_CTRL_MASK;
      `IO_EE_DATA:    io_rd = ee_data_reg;
      `IO_EE_ADDR_LO: io_rd = ee_addr_reg[7:0];
      `IO_EE_ADDR_HI: io_rd = {7'h00, ee_addr_reg[EE_AW-1:8]};
      default:        io_rd = 8'h00;
    endcase
  end

  // bit ops form a full-byte write image with only the addressed bit changed
  reg [7:0] bmask;
  reg [7:0] io_wimg;
  reg [7:0] flag_clr;
  reg       io_wr;
  always @* begin
    bmask = 8'h01 << bit_sel;
    io_wimg = wdata;
    flag_clr = 8'h00;
    io_wr = req && state_reg == S_IDLE && in_io && !unmapped &&
            ((is_store && bit_op == B_NONE) || bit_op == B_SET || bit_op == B_CLR);
    if (bit_op == B_SET)
      io_wimg = io_rd | bmask;
    else if (bit_op == B_CLR)
      io_wimg = io_rd & ~bmask;
    // write-one-to-clear: a bit set clears only the addressed flag, a bit clear leaves the flags alone
    if (bit_op == B_NONE)
      flag_clr = wdata;
    else if (bit_op == B_SET)
      flag_clr = bmask;
  end

  // -------------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      rdata_reg <= 8'h00;
      done_reg <= 1'b0;
      skip_reg <= 1'b0;
      stall_reg <= 1'b0;
      bad_op_reg <= 1'b0;
      ee_busy_reg <= 1'b0;
      flags_reg <= 8'h00;
      ee_ctrl_reg <= 8'h00;
      ee_data_reg <= 8'h00;
      ee_addr_reg <= {EE_AW{1'b0}};
      mwe_cnt_reg <= 3'h0;
      stall_cnt_reg <= 3'h0;
      sram_addr_reg <= 12'h000;
      sram_wr_reg <= 1'b0;
      sram_wd_reg <= 8'h00;
      ee_start_reg <= 1'b0;
      for (i = 0; i < 3; i = i + 1)
        gpr_reg[i] <= 8'h00;
    end else begin
      done_reg <= 1'b0;
      skip_reg <= 1'b0;
      bad_op_reg <= 1'b0;
      ee_start_reg <= 1'b0;
      ee_busy_reg <= ee_busy;
      // hardware set wins over a software clear in the same cycle
      flags_reg <= (flags_reg & ~((io_wr && ioa == `IO_FLAGS) ? flag_clr : 8'h00)) | flag_set;
      if (mwe_cnt_reg != 3'h0) begin
        mwe_cnt_reg <= mwe_cnt_reg - 3'h1;
        if (mwe_cnt_reg == 3'h1)
          ee_ctrl_reg[`EE_MWE_BIT] <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (req) begin
            if (unmapped) begin
              done_reg <= 1'b1;
              bad_op_reg <= 1'b1;
              rdata_reg <= 8'h00;
            end else if (in_sram) begin
              state_reg <= S_SRAM;
              sram_addr_reg <= addr - `DS_SRAM_FIRST;
              sram_wr_reg <= is_store;
              sram_wd_reg <= wdata;
            end else begin
              done_reg <= 1'b1;
              if (in_reg) begin
                rdata_reg <= regfile[addr[4:0]];
              end else if (in_ext) begin
                rdata_reg <= ext_io[addr[7:0] - 8'h60];
              end else begin
                rdata_reg <= io_rd;
                if (bit_op == B_SKIP)
                  skip_reg <= io_rd[bit_sel];
              end
              if (io_wr) begin
                case (ioa)
                  `IO_GPR0: gpr_reg[0] <= io_wimg;
                  `IO_GPR1: gpr_reg[1] <= io_wimg;
                  `IO_GPR2: gpr_reg[2] <= io_wimg;
                  `IO_EE_DATA:    if (!ee_busy) ee_data_reg <= io_wimg;
                  `IO_EE_ADDR_LO: if (!ee_busy) ee_addr_reg[7:0] <= io_wimg;
                  `IO_EE_ADDR_HI: if (!ee_busy) ee_addr_reg[EE_AW-1:8] <= io_wimg[EE_AW-9:0];
                  `IO_EE_CTRL: begin
                    if (io_wimg[`EE_MWE_BIT] && !ee_ctrl_reg[`EE_MWE_BIT]) begin
                      ee_ctrl_reg[`EE_MWE_BIT] <= 1'b1;
                      mwe_cnt_reg <= `EE_MWE_CYCLES;
                    end
                    if (io_wimg[`EE_WRITE_BIT] && ee_ctrl_reg[`EE_MWE_BIT] && !ee_busy) begin
                      ee_start_reg <= 1'b1;
                      stall_reg <= 1'b1;
                      done_reg <= 1'b0;
                      state_reg <= S_STALL;
                      stall_cnt_reg <= `EE_WRITE_STALL;
                    end else if (io_wimg[`EE_READ_BIT] && !ee_busy) begin
                      ee_data_reg <= ee_rdata;
                      stall_reg <= 1'b1;
                      done_reg <= 1'b0;
                      state_reg <= S_STALL;
                      stall_cnt_reg <= `EE_READ_STALL;
                    end
                  end
                  default: ;
                endcase
              end
            end
          end
        end
        S_SRAM: begin
          state_reg <= S_IDLE;
          done_reg <= 1'b1;
          if (!sram_wr_reg)
            rdata_reg <= sram[sram_addr_reg[SRAM_AW-1:0]];
        end
        S_STALL: begin
          stall_reg <= 1'b1;
          stall_cnt_reg <= stall_cnt_reg - 3'h1;
          if (stall_cnt_reg == 3'h1) begin
            stall_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // plain arrays, pointer update
  // -------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst && req && state_reg == S_IDLE && !unmapped) begin
      if (mode == M_PREDEC || mode == M_POSTIN) begin
        regfile[plo] <= ptr_new[7:0];
        regfile[plo + 5'h01] <= ptr_new[15:8];
      end
      if (is_store && bit_op == B_NONE && in_reg)
        regfile[addr[4:0]] <= wdata;
      if (is_store && in_ext)
        ext_io[addr[7:0] - 8'h60] <= wdata;
    end
    if (!rst && state_reg == S_SRAM && sram_wr_reg)
      sram[sram_addr_reg[SRAM_AW-1:0]] <= sram_wd_reg;
  end
endmodule // data_space_decoder

// [hdl/data_space_regs.vh]
// address map, sizes and timing counts for the data-space decoder
`ifndef DATA_SPACE_REGS_VH
`define DATA_SPACE_REGS_VH
`define DS_REG_LAST     12'h01F
`define DS_IO_FIRST     12'h020
`define DS_IO_LAST      12'h05F
`define DS_EXT_FIRST    12'h060
`define DS_EXT_LAST     12'h0FF
`define DS_SRAM_FIRST   12'h100
`define DS_IO_OFFSET    12'h020
`define IO_BIT_LAST     6'h1F
`define IO_LAST         6'h3F
`define DISP_MAX        6'h3F
`define PTR_X_LO        5'h1A
`define PTR_Y_LO        5'h1C
`define PTR_Z_LO        5'h1E
`define IO_GPR0         6'h1E
`define IO_GPR1         6'h2A
`define IO_GPR2         6'h2B
`define IO_EE_CTRL      6'h1F
`define IO_EE_DATA      6'h20
`define IO_EE_ADDR_LO   6'h21
`define IO_EE_ADDR_HI   6'h22
`define IO_FLAGS        6'h15
`define EE_READ_BIT     0
`define EE_WRITE_BIT    1
`define EE_MWE_BIT      2
`define EE_CTRL_MASK    8'h3F
`define EE_READ_STALL   3'h4
`define EE_WRITE_STALL  3'h2
`define EE_MWE_CYCLES   3'h4
`define SRAM_CYCLES     2'h2
`define EE_WRITE_TIME   16'h0100
`endif

// [hdl/ee_store.v]
// data EEPROM array with self-timed write
`timescale 1ns/1ps
module ee_store #(
  parameter AW = 9,
  parameter WRITE_CYCLES = 256
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // access
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wdata,
  input  wire          write_start,
  output wire [7:0]    rdata,
  output reg           busy_reg
);
  reg [7:0]  mem [0:(1<<AW)-1];
  reg [15:0] cnt_reg;
  reg [AW-1:0] waddr_reg;
  reg [7:0]  wdat_reg;

  assign rdata = mem[addr];

  // busy keeps counting through a core reset so a started write completes; only
  // write_start's absence under reset matters, the counter has no reset itself
  always @(posedge clk) begin
    if (write_start && !busy_reg) begin
      busy_reg  <= 1'b1;
      cnt_reg   <= WRITE_CYCLES[15:0];
      waddr_reg <= addr;
      wdat_reg  <= wdata;
    end else if (busy_reg) begin
      if (cnt_reg == 16'h0001) begin
        mem[waddr_reg] <= wdat_reg;
        busy_reg       <= 1'b0;
      end
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  initial busy_reg = 1'b0;
endmodule // ee_store

// [verif/cpu_port_model.sv]
// load/store and I/O unit model issuing one data-space access at a time
`timescale 1ns/1ps
module cpu_port_model (
  // clock
  input  wire         clk,
  // request
  output logic        req,
  output logic [2:0]  mode,
  output logic [1:0]  ptr_sel,
  output logic [11:0] direct_addr,
  output logic [5:0]  disp,
  output logic        is_store,
  output logic        io_op,
  output logic [1:0]  bit_op,
  output logic [2:0]  bit_sel,
  output logic [5:0]  io_addr,
  output logic [7:0]  wdata,
  // answer
  input  wire [7:0]   rdata_reg,
  input  wire         done_reg,
  input  wire         skip_reg,
  input  wire         stall_reg,
  input  wire         bad_op_reg
);
  logic [7:0] rd, sk, bad, cyc, stl;
  logic       hung = 1'b0;
  initial begin
    {req, mode, ptr_sel, direct_addr, disp, is_store} = '0;
    {io_op, bit_op, bit_sel, io_addr, wdata} = '0;
  end
  // one access; released address, displacement and data lines are inverted so stale values never look valid
  task automatic put(input [2:0] m, input [1:0] p, input [11:0] a, input [5:0] d,
    input s, input o, input [1:0] b, input [2:0] n, input [5:0] i, input [7:0] w);
    begin
      @(negedge clk);
      {mode, ptr_sel, direct_addr, disp, is_store} = {m, p, a, d, s};
      {io_op, bit_op, bit_sel, io_addr, wdata} = {o, b, n, i, w};
      req = 1'b1;
      // done can already be launched by the taking edge; look just after every edge so that
      // req is gone before an idle decoder could take the same access twice
      cyc = 8'h00;
      stl = 8'h00;
      do begin
        @(posedge clk);
        #1;
        cyc++;
        if (stall_reg) stl++;
      end while (done_reg !== 1'b1 && cyc < 8'h40);
      if (cyc == 8'h40) hung = 1'b1;
      {rd, sk, bad} = {rdata_reg, 7'h00, skip_reg, 7'h00, bad_op_reg};
      @(negedge clk);
      req = 1'b0;
      {direct_addr, disp, io_addr, wdata} = ~{direct_addr, disp, io_addr, wdata};
    end
  endtask
endmodule // cpu_port_model

// [verif/data_space_decoder_sva.sv]
// port assertions for the data-space decoder
`timescale 1ns/1ps
module data_space_decoder_sva #(
  parameter SRAM_AW = 10
) (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // request
  input wire        req,
  input wire [2:0]  mode,
  input wire [11:0] direct_addr,
  input wire        is_store,
  input wire        io_op,
  input wire [1:0]  bit_op,
  input wire [5:0]  io_addr,
  input wire [7:0]  wdata,
  // answer
  input wire        done_reg,
  input wire        skip_reg,
  input wire        stall_reg,
  input wire        bad_op_reg,
  input wire        ee_busy_reg
);
  localparam [11:0] TOP = 12'h100 + (12'h001 << SRAM_AW) - 12'h001;
  logic [2:0] run_reg;
  logic       dat;
  logic       iob;
  assign dat = req && mode == 3'h0 && !io_op;
  assign iob = req && io_op && bit_op != 2'h0;
  // stall run length; a runaway stall wraps but trips the cap first
  always @(posedge clk or posedge rst) begin
    if (rst)
      run_reg <= 3'h0;
    else
      run_reg <= stall_reg ? run_reg + 3'h1 : 3'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reg_direct: assert property ($rose(req) && dat && direct_addr <= 12'h01F
    |=> done_reg && !bad_op_reg) else $error("register access late");
  a_io_read: assert property ($rose(req) && io_op && !is_store && bit_op == 2'h0
    |=> done_reg) else $error("io read late");
  a_sram_two: assert property ($rose(req) && dat && direct_addr >= 12'h100
    && direct_addr <= TOP |=> !done_reg ##1 done_reg && !bad_op_reg)
    else $error("sram access not two cycles");
  a_over_top: assert property ($rose(req) && dat && direct_addr > TOP
    |=> done_reg && bad_op_reg) else $error("access above space accepted");
  a_bit_high: assert property ($rose(req) && iob && io_addr > 6'h1F
    |=> done_reg && bad_op_reg) else $error("bit op above range accepted");
  a_skip_done: assert property (skip_reg |-> done_reg && !bad_op_reg)
    else $error("skip without clean done");
  a_ee_read: assert property ($rose(req) && io_op && is_store && !ee_busy_reg
    && bit_op == 2'h0 && io_addr == 6'h1F && wdata[1:0] == 2'b01
    |=> stall_reg [*4] ##1 !stall_reg) else $error("eeprom read stall wrong");
  a_stall_quiet: assert property (stall_reg |-> !done_reg)
    else $error("done during stall");
  a_stall_cap: assert property (run_reg <= 3'h4)
    else $error("stall longer than four");
  a_stall_len: assert property ($fell(stall_reg) |-> run_reg == 3'h2 || run_reg == 3'h4)
    else $error("stall neither two nor four cycles");
endmodule // data_space_decoder_sva
bind data_space_decoder data_space_decoder_sva #(.SRAM_AW(SRAM_AW)) u_data_space_decoder_sva (
  .clk(clk), .rst(rst), .req(req), .mode(mode), .direct_addr(direct_addr),
  .is_store(is_store), .io_op(io_op), .bit_op(bit_op), .io_addr(io_addr), .wdata(wdata),
  .done_reg(done_reg), .skip_reg(skip_reg), .stall_reg(stall_reg),
  .bad_op_reg(bad_op_reg), .ee_busy_reg(ee_busy_reg));

// [verif/tb.sv]
// self-checking bench for the data-space decoder
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  flag_set = 8'h00;
  logic        req, is_store, io_op, done_reg, skip_reg, stall_reg, bad_op_reg, ee_busy_reg;
  logic [2:0]  mode, bit_sel;
  logic [1:0]  ptr_sel, bit_op;
  logic [11:0] direct_addr;
  logic [5:0]  disp, io_addr;
  logic [7:0]  wdata, rdata_reg;
  integer      num_errors = 0;
  integer      checks_done = 0;
  always #20 clk = ~clk;
  // short write time keeps the eeprom scenarios brief
  data_space_decoder #(.SRAM_AW(10), .EE_AW(9), .EE_WRITE_CYCLES(8)) u_data_space_decoder (
    .clk(clk), .rst(rst), .req(req), .mode(mode), .ptr_sel(ptr_sel),
    .direct_addr(direct_addr), .disp(disp), .is_store(is_store), .io_op(io_op),
    .bit_op(bit_op), .bit_sel(bit_sel), .io_addr(io_addr), .wdata(wdata),
    .flag_set(flag_set), .rdata_reg(rdata_reg), .done_reg(done_reg), .skip_reg(skip_reg),
    .stall_reg(stall_reg), .bad_op_reg(bad_op_reg), .ee_busy_reg(ee_busy_reg));
  cpu_port_model u_cpu_port_model (
    .clk(clk), .req(req), .mode(mode), .ptr_sel(ptr_sel), .direct_addr(direct_addr),
    .disp(disp), .is_store(is_store), .io_op(io_op), .bit_op(bit_op), .bit_sel(bit_sel),
    .io_addr(io_addr), .wdata(wdata), .rdata_reg(rdata_reg), .done_reg(done_reg),
    .skip_reg(skip_reg), .stall_reg(stall_reg), .bad_op_reg(bad_op_reg));
  task automatic finish_test;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge u_cpu_port_model.hung) begin
    num_errors++;
    $display("CHECK FAILED %0t: no answer", $time);
    finish_test;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    begin
      checks_done++;
      if (g !== e) begin
        num_errors++;
        $display("CHECK FAILED %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task automatic ld(input [11:0] a);
    u_cpu_port_model.put(0, 0, a, 0, 0, 0, 0, 0, 0, 0);
  endtask
  task automatic sto(input [11:0] a, input [7:0] w);
    u_cpu_port_model.put(0, 0, a, 0, 1, 0, 0, 0, 0, w);
  endtask
  task automatic iow(input [5:0] i, input s, input [7:0] w);
    u_cpu_port_model.put(0, 0, 0, 0, s, 1, 0, 0, i, w);
  endtask
  task automatic bop(input [1:0] b, input [5:0] i, input [2:0] n);
    u_cpu_port_model.put(0, 0, 0, 0, 0, 1, b, n, i, 0);
  endtask
  task automatic ptr(input [2:0] m, input [1:0] p, input [5:0] d, input [7:0] w);
    u_cpu_port_model.put(m, p, 0, d, 1, 0, 0, 0, 0, w);
  endtask
  // busy flag lags the strobe by two cycles, so look only after two
  task automatic ee_idle;
    integer n;
    begin
      repeat (2) @(negedge clk);
      for (n = 0; n < 100 && ee_busy_reg !== 1'b0; n++) @(negedge clk);
      if (n == 100) begin
        chk(8'h01, 8'h00);
        finish_test;
      end
    end
  endtask
  task automatic t_map;
    begin
      sto(12'h005, 8'h3C);
      chk(u_cpu_port_model.cyc, 8'h01);
      ld(12'h005);
      chk(u_cpu_port_model.rd, 8'h3C);
      sto(12'h060, 8'h81);
      ld(12'h060);
      chk(u_cpu_port_model.rd, 8'h81);
      iow(6'h2A, 1'b1, 8'h5A);
      ld(12'h04A);
      chk(u_cpu_port_model.rd, 8'h5A);
      iow(6'h01, 1'b0, 8'h00);
      chk(u_cpu_port_model.rd, 8'h00);
      sto(12'h4FF, 8'h22);
      chk(u_cpu_port_model.cyc, 8'h02);
      ld(12'h4FF);
      chk(u_cpu_port_model.rd, 8'h22);
      ld(12'h500);
      chk(u_cpu_port_model.bad, 8'h01);
    end
  endtask
  task automatic t_bits;
    begin
      iow(6'h1E, 1'b1, 8'h00);
      bop(2'h1, 6'h1E, 3'h3);
      bop(2'h1, 6'h1E, 3'h5);
      bop(2'h2, 6'h1E, 3'h5);
      ld(12'h03E);
      chk(u_cpu_port_model.rd, 8'h08);
      bop(2'h3, 6'h1E, 3'h3);
      chk(u_cpu_port_model.sk, 8'h01);
      bop(2'h3, 6'h1E, 3'h2);
      chk(u_cpu_port_model.sk, 8'h00);
      bop(2'h1, 6'h2A, 3'h0);
      chk(u_cpu_port_model.bad, 8'h01);
      @(negedge clk);
      flag_set = 8'hFF;
      @(negedge clk);
      flag_set = 8'h00;
      iow(6'h15, 1'b1, 8'h01);
      iow(6'h15, 1'b0, 8'h00);
      chk(u_cpu_port_model.rd, 8'hFE);
      bop(2'h2, 6'h15, 3'h4);
      bop(2'h1, 6'h15, 3'h7);
      iow(6'h15, 1'b0, 8'h00);
      chk(u_cpu_port_model.rd, 8'h7E);
    end
  endtask
  task automatic t_ptr;
    begin
      sto(12'h01A, 8'h00);
      sto(12'h01B, 8'h01);
      ptr(3'h4, 2'h0, 6'h00, 8'h77);
      ld(12'h01A);
      chk(u_cpu_port_model.rd, 8'h01);
      ptr(3'h3, 2'h0, 6'h00, 8'h66);
      ld(12'h100);
      chk(u_cpu_port_model.rd, 8'h66);
      sto(12'h01C, 8'h00);
      sto(12'h01D, 8'h01);
      ptr(3'h1, 2'h1, 6'h3F, 8'h99);
      ld(12'h13F);
      chk(u_cpu_port_model.rd, 8'h99);
    end
  endtask
  task automatic t_ee;
    begin
      iow(6'h21, 1'b1, 8'h05);
      iow(6'h22, 1'b1, 8'h00);
      iow(6'h20, 1'b1, 8'hA5);
      iow(6'h1F, 1'b1, 8'h04);
      iow(6'h1F, 1'b1, 8'h02);
      chk(u_cpu_port_model.stl, 8'h02);
      ee_idle;
      iow(6'h20, 1'b1, 8'h3C);
      iow(6'h1F, 1'b1, 8'h04);
      repeat (6) @(negedge clk);
      iow(6'h1F, 1'b1, 8'h02);
      repeat (2) @(negedge clk);
      chk({7'h00, ee_busy_reg}, 8'h00);
      iow(6'h1F, 1'b1, 8'h01);
      chk(u_cpu_port_model.stl, 8'h04);
      iow(6'h20, 1'b0, 8'h00);
      chk(u_cpu_port_model.rd, 8'hA5);
      iow(6'h20, 1'b1, 8'hC3);
      iow(6'h1F, 1'b1, 8'h04);
      iow(6'h1F, 1'b1, 8'h02);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      ee_idle;
      iow(6'h21, 1'b1, 8'h05);
      iow(6'h22, 1'b1, 8'h00);
      iow(6'h1F, 1'b1, 8'h01);
      iow(6'h20, 1'b0, 8'h00);
      chk(u_cpu_port_model.rd, 8'hC3);
    end
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_map;
    t_bits;
    t_ptr;
    t_ee;
    finish_test;
  end
endmodule // tb
